// ### hdl/sbc_pkg.sv
package sbc_pkg;
   // Core clock and serial bit timing
   localparam int unsigned CLK_KHZ       = 50000;
   localparam int unsigned HALF_BIT_NS   = 2000;
   localparam int unsigned HALF_BIT_CYC  =
      (HALF_BIT_NS * CLK_KHZ + 999999) / 1000000;
   localparam int unsigned XFER_LIMIT_NS = 88800;
   // Scaled in two steps so the product stays inside 32 bits
   localparam int unsigned XFER_LIMIT_CYC =
      XFER_LIMIT_NS * (CLK_KHZ / 1000) / 1000;
   // Operand values with a fixed meaning
   localparam logic [3:0] SELECT_OPERAND = 4'h7;
   localparam logic [3:0] FORMAT_OPERAND = 4'h3;
   // Values after reset
   localparam logic [3:0] SELECT_RESET   = 4'h0;
   localparam logic       FORMAT_RESET   = 1'b0;
   // Port code top bit per direction
   localparam logic       CODE_MSB_OUT   = 1'b1;
   localparam logic       CODE_MSB_IN    = 1'b0;
   localparam logic [1:0] LAST_BIT       = 2'h3;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_CODE = 4'b0010,
      ST_STRB = 4'b0100,
      ST_DATA = 4'b1000
   } sbc_state_t;
endpackage : sbc_pkg

// ### hdl/sbc_serial_bus_ctrl.sv
`timescale 1ns/1ns
module sbc_serial_bus_ctrl
#(
   parameter int unsigned HALF_CYC = sbc_pkg::HALF_BIT_CYC
)
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Instruction strobes from the core
   input  wire logic       sio_out_i,
   input  wire logic       sio_in_i,
   input  wire logic       key_out_i,
   input  wire logic       key_in_i,
   input  wire logic [3:0] port_code_operand_i,
   input  wire logic [3:0] payload_i,
   // Results to the core
   output logic       busy_o,
   output logic       done_o,
   output logic [3:0] rx_payload_o,
   output logic       key_rdata_o,
   output logic [3:0] peer_select_o,
   // Serial bus pins
   output logic       data_out_o,
   input  wire logic  data_in_i,
   output logic       shift_clock_line_o,
   output logic       frame_strobe_line_o
);
   localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
   localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);

   sbc_pkg::sbc_state_t state_reg, state_next;
   logic [CW-1:0] hcnt_reg, hcnt_next;
   logic          phase_reg, phase_next;
   logic [1:0]    bit_reg, bit_next;
   logic          dir_in_reg, dir_in_next;
   logic [3:0]    sh_reg, sh_next;
   logic [3:0]    data_reg, data_next;
   logic [3:0]    rx_reg, rx_next;
   logic [3:0]    peer_select_port_reg, peer_select_port_next;
   logic          data_only_format_reg, data_only_format_next;
   logic          key_rdata_reg, key_rdata_next;
   logic          clk_reg, clk_next;
   logic          stb_reg, stb_next;
   logic          so_reg, so_next;
   logic          busy_reg, busy_next;
   logic          done_reg, done_next;
   logic [3:0]    rdata_reg, rdata_next;
   logic [3:0]    sel_out_reg, sel_out_next;
   logic          si_meta_reg;
   logic          si_sync_reg;
   logic          tick;
   logic          start;

   // Operand decodes shared by the start check, writes and reads
   function automatic logic sel_port(input logic [3:0] operand);
      sel_port = (operand == sbc_pkg::SELECT_OPERAND);
   endfunction : sel_port

   function automatic logic fmt_port(input logic [3:0] operand);
      fmt_port = (operand == sbc_pkg::FORMAT_OPERAND);
   endfunction : fmt_port

   // Data-in pin is asynchronous to the core clock
   // Sync costs two cycles: a peer must settle its bit within
   // 2*HALF_CYC-2 cycles of a falling edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         si_meta_reg <= 1'b0;
         si_sync_reg <= 1'b0;
      end
      else
      begin
         si_meta_reg <= data_in_i;
         si_sync_reg <= si_meta_reg;
      end
   end

   assign tick  = (hcnt_reg == HALF_LAST);
   // Select write takes priority over a transfer on operand 7
   assign start = (sio_out_i && !sel_port(port_code_operand_i))
                  || sio_in_i;

   always_comb
   begin
      state_next            = state_reg;
      hcnt_next             = hcnt_reg;
      phase_next            = phase_reg;
      bit_next              = bit_reg;
      dir_in_next           = dir_in_reg;
      sh_next               = sh_reg;
      data_next             = data_reg;
      rx_next               = rx_reg;
      peer_select_port_next = peer_select_port_reg;
      data_only_format_next = data_only_format_reg;
      key_rdata_next        = key_rdata_reg;
      clk_next              = clk_reg;
      stb_next              = stb_reg;
      so_next               = so_reg;
      busy_next             = busy_reg;
      done_next             = 1'b0;
      rdata_next            = rdata_reg;
      sel_out_next          = sel_out_reg;

      // Register-port writes are refused while the bus is busy
      if (!busy_reg && sio_out_i && sel_port(port_code_operand_i))
         peer_select_port_next = payload_i;
      // Format cannot flip under a running transfer
      if (!busy_reg && key_out_i && fmt_port(port_code_operand_i))
         data_only_format_next = payload_i[0];
      if (key_in_i && fmt_port(port_code_operand_i))
         key_rdata_next = data_only_format_reg;

      // Select code only reaches peers in framed format
      sel_out_next = data_only_format_reg ? 4'h0 : peer_select_port_reg;

      case (state_reg)
         sbc_pkg::ST_IDLE:
         begin
            clk_next = 1'b1;
            stb_next = 1'b0;
            if (start && !busy_reg)
            begin
               busy_next   = 1'b1;
               dir_in_next = sio_in_i;
               hcnt_next   = '0;
               phase_next  = 1'b0;
               bit_next    = 2'h0;
               clk_next    = 1'b0;
               data_next   = sio_in_i ? 4'h0 : payload_i;
               if (!data_only_format_reg)
               begin
                  state_next = sbc_pkg::ST_CODE;
                  sh_next    = {sio_in_i ? sbc_pkg::CODE_MSB_IN
                                         : sbc_pkg::CODE_MSB_OUT,
                                port_code_operand_i[2:0]};
                  so_next    = port_code_operand_i[0];
               end
               else
               begin
                  // Operand ignored, nibble only
                  state_next = sbc_pkg::ST_DATA;
                  sh_next    = sio_in_i ? 4'h0 : payload_i;
                  so_next    = sio_in_i ? 1'b0 : payload_i[0];
                  if (sio_in_i)
                     rx_next = {si_sync_reg, rx_reg[3:1]};
               end
            end
         end
         sbc_pkg::ST_CODE,
         sbc_pkg::ST_DATA:
         begin
            hcnt_next = tick ? '0 : CW'(hcnt_reg + 1'b1);
            if (tick && !phase_reg)
            begin
               phase_next = 1'b1;
               clk_next   = 1'b1;
            end
            else if (tick)
            begin
               phase_next = 1'b0;
               if (bit_reg != sbc_pkg::LAST_BIT)
               begin
                  // Next bit launched on the falling edge, LSB first
                  bit_next = bit_reg + 2'h1;
                  sh_next  = {1'b0, sh_reg[3:1]};
                  so_next  = sh_reg[1];
                  clk_next = 1'b0;
                  if (state_reg == sbc_pkg::ST_DATA && dir_in_reg)
                     rx_next = {si_sync_reg, rx_reg[3:1]};
               end
               else if (state_reg == sbc_pkg::ST_CODE)
               begin
                  // Strobe marks the end of the code field
                  state_next = sbc_pkg::ST_STRB;
                  stb_next   = 1'b1;
                  so_next    = 1'b0;
               end
               else
               begin
                  // Finished well inside one instruction time
                  state_next = sbc_pkg::ST_IDLE;
                  busy_next  = 1'b0;
                  done_next  = 1'b1;
                  so_next    = 1'b0;
                  if (dir_in_reg)
                     rdata_next = rx_reg;
               end
            end
         end
         // Strobe high for one half bit, shift clock held high
         sbc_pkg::ST_STRB:
         begin
            hcnt_next = tick ? '0 : CW'(hcnt_reg + 1'b1);
            if (tick && !phase_reg)
            begin
               phase_next = 1'b1;
               stb_next   = 1'b0;
            end
            else if (tick)
            begin
               phase_next = 1'b0;
               state_next = sbc_pkg::ST_DATA;
               bit_next   = 2'h0;
               sh_next    = data_reg;
               so_next    = data_reg[0];
               clk_next   = 1'b0;
               if (dir_in_reg)
                  rx_next = {si_sync_reg, rx_reg[3:1]};
            end
         end
         default:
         begin
            state_next = sbc_pkg::ST_IDLE;
            busy_next  = 1'b0;
            clk_next   = 1'b1;
            stb_next   = 1'b0;
            so_next    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg            <= sbc_pkg::ST_IDLE;
         hcnt_reg             <= '0;
         phase_reg            <= 1'b0;
         bit_reg              <= 2'h0;
         dir_in_reg           <= 1'b0;
         sh_reg               <= 4'h0;
         data_reg             <= 4'h0;
         rx_reg               <= 4'h0;
         peer_select_port_reg <= sbc_pkg::SELECT_RESET;
         data_only_format_reg <= sbc_pkg::FORMAT_RESET;
         key_rdata_reg        <= 1'b0;
         clk_reg              <= 1'b1;
         stb_reg              <= 1'b0;
         so_reg               <= 1'b0;
         busy_reg             <= 1'b0;
         done_reg             <= 1'b0;
         rdata_reg            <= 4'h0;
         sel_out_reg          <= 4'h0;
      end
      else
      begin
         state_reg            <= state_next;
         hcnt_reg             <= hcnt_next;
         phase_reg            <= phase_next;
         bit_reg              <= bit_next;
         dir_in_reg           <= dir_in_next;
         sh_reg               <= sh_next;
         data_reg             <= data_next;
         rx_reg               <= rx_next;
         peer_select_port_reg <= peer_select_port_next;
         data_only_format_reg <= data_only_format_next;
         key_rdata_reg        <= key_rdata_next;
         clk_reg              <= clk_next;
         stb_reg              <= stb_next;
         so_reg               <= so_next;
         busy_reg             <= busy_next;
         done_reg             <= done_next;
         rdata_reg            <= rdata_next;
         sel_out_reg          <= sel_out_next;
      end
   end

   // Three driven bus lines and the core results, all straight from flops
   assign shift_clock_line_o  = clk_reg;
   assign frame_strobe_line_o = stb_reg;
   assign data_out_o          = so_reg;
   assign busy_o              = busy_reg;
   assign done_o              = done_reg;
   assign rx_payload_o        = rdata_reg;
   assign key_rdata_o         = key_rdata_reg;
   assign peer_select_o       = sel_out_reg;
endmodule : sbc_serial_bus_ctrl

// ### testbench/sbc_sva.sv
`timescale 1ns/1ns
module sbc_sva
#(
   parameter int unsigned HALF_CYC = 2
)
(
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_i,
   // Core side
   input wire logic       sio_out_i,
   input wire logic       sio_in_i,
   input wire logic       key_out_i,
   input wire logic       key_in_i,
   input wire logic [3:0] port_code_operand_i,
   input wire logic [3:0] payload_i,
   input wire logic       busy_o,
   input wire logic       done_o,
   input wire logic       key_rdata_o,
   input wire logic [3:0] peer_select_o,
   // Bus side
   input wire logic       data_out_o,
   input wire logic       shift_clock_line_o,
   input wire logic       frame_strobe_line_o
);
   logic        fmt_reg;
   logic        dir_reg;
   logic        stb_reg;
   int unsigned cnt_reg;
   // Select writes on operand 7 never start a transfer
   wire logic   go = !busy_o && (sio_in_i ||
      sio_out_i && port_code_operand_i != 4'h7);
   wire logic   fmt_wr = key_out_i && !busy_o && port_code_operand_i == 4'h3;

   always_ff @(posedge clk_i)
   begin
      fmt_reg <= rst_i ? 1'b0 : (fmt_wr ? payload_i[0] : fmt_reg);
      dir_reg <= go ? sio_out_i : dir_reg;
      stb_reg <= !go && (stb_reg || frame_strobe_line_o);
      cnt_reg <= busy_o ? cnt_reg + 1 : 0;
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_go;
      go;
   endsequence
   sequence s_code_end;
      $rose(frame_strobe_line_o);
   endsequence

   a_idle_clock:
      assert property (!busy_o |-> shift_clock_line_o)
      else $error("shift clock low while idle");
   a_start_busy:
      assert property (s_go |=> busy_o && !shift_clock_line_o)
      else $error("transfer did not start");
   a_strobe_gap:
      assert property (frame_strobe_line_o |-> busy_o && shift_clock_line_o)
      else $error("strobe outside the field gap");
   a_code_msb:
      assert property (s_code_end |-> $past(data_out_o) == dir_reg)
      else $error("wrong top bit of port code");
   a_xfer_length:
      assert property (done_o |-> cnt_reg == (stb_reg ? 18 : 8) * HALF_CYC)
      else $error("transfer length wrong");
   a_raw_quiet:
      assert property (fmt_reg && busy_o |->
         !frame_strobe_line_o && (dir_reg || !data_out_o))
      else $error("data-only transfer drives strobe or data");
   a_select_hold:
      assert property (busy_o && $past(busy_o) |-> $stable(peer_select_o))
      else $error("select code changed in a transfer");
   a_format_read:
      assert property (key_in_i && port_code_operand_i == 4'h3 |=>
         key_rdata_o == fmt_reg)
      else $error("format readback wrong");
endmodule : sbc_sva

bind sbc_serial_bus_ctrl sbc_sva #(.HALF_CYC(HALF_CYC)) u_sva
(
   .clk_i(clk_i), .rst_i(rst_i), .sio_out_i(sio_out_i),
   .sio_in_i(sio_in_i), .key_out_i(key_out_i), .key_in_i(key_in_i),
   .port_code_operand_i(port_code_operand_i), .payload_i(payload_i),
   .busy_o(busy_o), .done_o(done_o), .key_rdata_o(key_rdata_o),
   .peer_select_o(peer_select_o), .data_out_o(data_out_o),
   .shift_clock_line_o(shift_clock_line_o),
   .frame_strobe_line_o(frame_strobe_line_o)
);

// ### testbench/sbc_peer.sv
`timescale 1ns/1ns
module sbc_peer
#(
   parameter logic [3:0] MY_SEL = 4'hf
)
(
   // Four bus lines plus bench controls
   input wire logic       clk_i,
   input wire logic       shift_clock_line_i,
   input wire logic       frame_strobe_line_i,
   input wire logic       data_out_i,
   input wire logic [3:0] peer_select_i,
   input wire logic       raw_i,
   input wire logic [3:0] port_val_i,
   output logic           data_in_o,
   output logic [7:0]     got_o
);
   logic       ck_d = 1'b1;
   logic       st_d = 1'b0;
   logic       tog = 1'b0;
   logic [2:0] n = 3'h0;
   logic [3:0] sh = 4'h0;
   // Released line toggles so a late sample never hits a stale bit
   assign data_in_o = (n != 3'h0) ? sh[0] : tog;

   always @(posedge clk_i)
   begin
      ck_d <= shift_clock_line_i;
      st_d <= frame_strobe_line_i;
      tog <= !tog;
      if (!ck_d && shift_clock_line_i)
         got_o <= {data_out_i, got_o[7:1]};
      // Only one peer per select code, and only on an input frame
      if (frame_strobe_line_i && !st_d)
      begin
         n <= (peer_select_i == MY_SEL && !got_o[7]) ? 3'h4 : 3'h0;
         sh <= port_val_i;
      end
      else if (ck_d && !shift_clock_line_i && n != 3'h0)
      begin
         n <= n - 3'h1;
         sh <= sh >> 1;
      end
      else if (raw_i && n == 3'h0)
      begin
         n <= 3'h4;
         sh <= port_val_i;
      end
   end
endmodule : sbc_peer

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int unsigned H = 2;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  strobes = 4'h0;
   logic [3:0]  op = 4'h0;
   logic [3:0]  pl = 4'h0;
   logic [3:0]  pv = 4'h0;
   logic        raw = 1'b0;
   logic        busy, done, krd, sdo, sdi, sck, stb;
   logic [3:0]  rx, sel;
   logic [7:0]  got;
   logic [16:0] e;
   logic [16:0] q[$];
   int          err_total = 0;
   int          compares = 0;

   sbc_serial_bus_ctrl #(.HALF_CYC(H)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .sio_out_i(strobes[3]),
      .sio_in_i(strobes[2]), .key_out_i(strobes[1]), .key_in_i(strobes[0]),
      .port_code_operand_i(op), .payload_i(pl), .busy_o(busy),
      .done_o(done), .rx_payload_o(rx), .key_rdata_o(krd),
      .peer_select_o(sel), .data_out_o(sdo), .data_in_i(sdi),
      .shift_clock_line_o(sck), .frame_strobe_line_o(stb));
   sbc_peer u_peer (.clk_i(clk_i), .shift_clock_line_i(sck),
      .frame_strobe_line_i(stb), .data_out_i(sdo), .peer_select_i(sel),
      .raw_i(raw), .port_val_i(pv), .data_in_o(sdi), .got_o(got));

   initial
      forever #10 clk_i = ~clk_i;

   task automatic chk(input string nm, input logic [7:0] x,
      input logic [7:0] s);
      compares++;
      if (s !== x)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   task automatic issue(input logic [3:0] k, input logic [3:0] o,
      input logic [3:0] d);
      strobes <= k;
      op <= o;
      pl <= d;
      @(posedge clk_i);
      strobes <= 4'h0;
      @(posedge clk_i);
   endtask : issue

   task automatic xfer(input logic [3:0] k, input logic [3:0] o,
      input logic [3:0] d, input logic [16:0] x);
      q.push_back(x);
      issue(k, o, d);
      for (int i = 0; i < 40 * H && done !== 1'b1; i++)
         @(negedge clk_i);
      chk("done", 8'h01, {7'h0, done});
      @(posedge clk_i);
   endtask : xfer

   task automatic pair(input logic [3:0] o, input logic [3:0] d,
      input logic [3:0] p);
      logic [7:0] m;
      logic [3:0] c;
      m = raw ? 8'hf0 : 8'hff;
      c = raw ? 4'h0 : {1'b0, o[2:0]};
      pv <= p;
      xfer(4'h8, o, d, {1'b0, m, d, c | {~raw, 3'h0}});
      @(posedge clk_i);
      xfer(4'h4, o, d, {1'b1, m, p, c});
   endtask : pair

   task automatic conclude;
      if (q.size() != 0)
         err_total++;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   // Monitor pairs every finished transfer with the oldest expectation
   always @(negedge clk_i)
      if (done === 1'b1)
      begin
         e = q.pop_front();
         chk("transfer", e[7:0],
             e[15:8] & (e[16] ? {rx, got[3:0]} : got));
      end

   initial
   begin
      logic [3:0] o;
      void'($urandom(32'hcd8779fa));
      repeat (10)
         @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      issue(4'h1, 4'h3, 4'h0);
      chk("format", 8'h00, {7'h0, krd});
      for (int i = 0; i < 16; i++)
      begin
         issue(4'h8, 4'h7, 4'(i));
         @(posedge clk_i);
         chk("select", 8'(i), {4'h0, sel});
      end
      for (int k = 0; k < 10; k++)
      begin
         if (k == 6)
         begin
            chk("select", 8'h0f, {4'h0, sel});
            issue(4'h2, 4'h3, 4'h1);
            issue(4'h1, 4'h2, 4'h0);
            chk("format", 8'h00, {7'h0, krd});
            raw <= 1'b1;
            issue(4'h1, 4'h3, 4'h0);
            chk("format", 8'h01, {7'h0, krd});
            chk("select", 8'h00, {4'h0, sel});
         end
         o = 4'($urandom);
         if (o == 4'h7)
            o = 4'h6;
         pair(o, 4'($urandom), 4'($urandom));
      end
      conclude();
   end

   // Whole run needs about 680 cycles; 5000 leaves ample margin
   initial
   begin
      #100000;
      err_total++;
      conclude();
   end
endmodule : testbench
